//--- verilog/eac_pkg.sv
// package: constants and types of the nonvolatile access control block
// Function
// - bits 7..6 of the control register always read as zero
// - mode field picks atomic (3.4 ms), erase (1.8 ms), write (1.8 ms), 11 reserved
// - writes to the mode field are ignored while the program strobe is set
// - reset clears the mode field to 00 unless programming is in progress
// - ready interrupt requested continuously while enabled, global flag set, strobe zero
// - hardware clears master program enable four cycles after software sets it
// - strobe set inside the enable window programs data register at address register
// - strobe write while master enable is zero has no effect
// - no programming cycle starts while the CPU is writing program flash
// - hardware clears the program strobe when programming time has elapsed
// - CPU halted two cycles after the program strobe is set
// - read strobe fetches addressed byte into the data register at once
// - CPU halted four cycles after a read strobe; two if the same control write also starts programming
// - during programming, reads are refused and the address register is frozen
// - programming time counted in RC oscillator cycles, 26,368 for a CPU write
// - data register supplies write data and receives read data
// - address register selects one of 512 bytes linearly
package eac_pkg;
    localparam logic [7:0]  EAC_OFF_CTRL  = 8'h00;
    localparam logic [7:0]  EAC_OFF_ADDR  = 8'h04;
    localparam logic [7:0]  EAC_OFF_DATA  = 8'h08;
    localparam int          EAC_BIT_RE    = 0;
    localparam int          EAC_BIT_PE    = 1;
    localparam int          EAC_BIT_MPE   = 2;
    localparam int          EAC_BIT_RIE   = 3;
    localparam int          EAC_MODE_LO   = 4;
    localparam int          EAC_MODE_HI   = 5;
    localparam logic [1:0]  EAC_MODE_ATOM = 2'h0;
    localparam logic [1:0]  EAC_MODE_ERAS = 2'h1;
    localparam logic [1:0]  EAC_MODE_WRIT = 2'h2;
    localparam logic [1:0]  EAC_MODE_RSVD = 2'h3;
    localparam logic [1:0]  EAC_MODE_RST  = 2'h0;
    localparam logic [2:0]  EAC_MPE_WIN   = 3'h4;
    localparam logic [2:0]  EAC_HALT_PROG = 3'h2;
    localparam logic [2:0]  EAC_HALT_READ = 3'h4;
    localparam int          EAC_T_ATOM_US = 3400;
    localparam int          EAC_T_SPLT_US = 1800;
    localparam int          EAC_RC_ATOM   = 26368;
    localparam int          EAC_RC_SPLT   = EAC_RC_ATOM * EAC_T_SPLT_US / EAC_T_ATOM_US;
    localparam int          EAC_TMR_W     = 16;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_PROG = 2'h1,
        ENG_DONE = 2'h3
    } eac_eng_t;
endpackage

//--- verilog/eac_timer_if.sv
// interface: start and done handshake between control and RC timer
`timescale 1ns/10ps
interface eac_timer_if;
    logic        start;
    logic [15:0] cycles;
    logic        done;
    modport ctrl  (output start, output cycles, input done);
    modport timer (input start, input cycles, output done);
endinterface

//--- verilog/eac_rc_timer.sv
// module: counts RC oscillator cycles for one programming cycle
`timescale 1ns/10ps
module eac_rc_timer
    import eac_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   por_n,
    input  wire logic   rc_clk_in,
    eac_timer_if.timer  tif
);
    logic                 sync1;
    logic                 sync2;
    logic                 sync3;
    logic [EAC_TMR_W-1:0] cnt;
    logic [EAC_TMR_W-1:0] next_cnt;
    logic                 done;
    logic                 next_done;
    logic                 tick;

    assign tick     = sync2 & ~sync3;
    assign tif.done = done;

    // each rising RC edge counts one cycle
    always_comb begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (tif.start) begin
            next_cnt = tif.cycles;
        end else if (tick && cnt != '0) begin
            next_cnt = cnt - 1'b1;
            if (cnt == 16'h0001) begin
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            cnt   <= '0;
            done  <= 1'b0;
        end else begin
            sync1 <= rc_clk_in;
            sync2 <= sync1;
            sync3 <= sync2;
            cnt   <= next_cnt;
            done  <= next_done;
        end
    end
endmodule

//--- verilog/eac_top.sv
// module: APB control of the data EEPROM: arming, timing, reads and CPU stalls
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
module eac_top
    import eac_pkg::*;
#(
    parameter int ADDR_W         = 9,
    parameter int PROG_RC_ATOMIC = EAC_RC_ATOM,
    parameter int PROG_RC_SPLIT  = EAC_RC_SPLT
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              por_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              gie,
    input  wire logic              self_program_enable,
    input  wire logic              rc_clk_in,
    input  wire logic [7:0]        ee_rdata,
    output logic      [ADDR_W-1:0] ee_addr,
    output logic      [7:0]        ee_wdata,
    output logic                   ee_erase,
    output logic                   ee_write,
    output logic                   ee_read,
    output logic                   cpu_halt,
    output logic                   ready_irq
);
    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic eac_hit(input logic [7:0] a, input logic [7:0] off);
        eac_hit = (a == off);
    endfunction

    eac_timer_if tif ();

    logic              setup;
    logic              acc;
    logic              ctrl_wr;
    logic              addr_wr;
    logic              data_wr;
    logic              mapped;
    logic              start;
    logic              rd_go;
    logic              mpe_set;
    logic              ready_irq_enable;
    logic              master_program_enable;
    logic              program_strobe;
    logic [1:0]        prog_mode_field;
    logic [2:0]        mpe_cnt;
    logic [2:0]        halt_cnt;
    logic [7:0]        ctrl_rd;
    logic              rst_q1;
    logic              sys_run;
    eac_eng_t          state;
    logic              tstart;
    logic [15:0]       tcycles;

    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              next_rie;
    logic              next_mpe;
    logic [2:0]        next_mpe_cnt;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0]        next_data;
    logic              next_read;
    logic [2:0]        next_halt_cnt;
    logic              next_halt;
    logic              next_irq;
    eac_eng_t          next_state;
    logic              next_pe;
    logic [1:0]        next_mode;
    logic              next_erase;
    logic              next_write;
    logic              next_tstart;
    logic [15:0]       next_tcycles;

    assign setup   = psel & ~penable;
    assign acc     = psel & penable & pready;
    assign ctrl_wr = acc & pwrite & eac_hit(paddr, EAC_OFF_CTRL);
    assign addr_wr = acc & pwrite & eac_hit(paddr, EAC_OFF_ADDR);
    assign data_wr = acc & pwrite & eac_hit(paddr, EAC_OFF_DATA);
    assign mapped  = eac_hit(paddr, EAC_OFF_CTRL) | eac_hit(paddr, EAC_OFF_ADDR)
                   | eac_hit(paddr, EAC_OFF_DATA);
    assign mpe_set = ctrl_wr & pwdata[EAC_BIT_MPE];
    assign start   = ctrl_wr & pwdata[EAC_BIT_PE] & master_program_enable
                   & ~program_strobe & ~self_program_enable;
    assign rd_go   = ctrl_wr & pwdata[EAC_BIT_RE] & ~program_strobe;
    assign ctrl_rd = {2'b00, prog_mode_field, ready_irq_enable,
                      master_program_enable, program_strobe, 1'b0};
    assign tif.start  = tstart;
    assign tif.cycles = tcycles;

    eac_rc_timer u_timer (
        .pclk      (pclk),
        .por_n     (por_n),
        .rc_clk_in (rc_clk_in),
        .tif       (tif)
    );

    // ****************************************************************
    // APB slave: answer registered in the access phase
    // ****************************************************************
    always_comb begin
        next_pready  = setup;
        next_pslverr = setup & ~mapped;
        next_prdata  = prdata;
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite && eac_hit(paddr, EAC_OFF_CTRL)) begin
                next_prdata = {24'h00_0000, ctrl_rd};
            end else if (!pwrite && eac_hit(paddr, EAC_OFF_ADDR)) begin
                next_prdata = {{(32-ADDR_W){1'b0}}, ee_addr};
            end else if (!pwrite && eac_hit(paddr, EAC_OFF_DATA)) begin
                next_prdata = {24'h00_0000, ee_wdata};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // software-side control: enable window, address, data, stalls
    // ****************************************************************
    always_comb begin
        next_rie      = ctrl_wr ? pwdata[EAC_BIT_RIE] : ready_irq_enable;
        next_mpe      = master_program_enable;
        next_mpe_cnt  = mpe_cnt;
        next_addr     = ee_addr;
        next_data     = ee_wdata;
        next_read     = rd_go;
        next_halt_cnt = halt_cnt;
        if (mpe_set) begin
            next_mpe     = 1'b1;
            next_mpe_cnt = EAC_MPE_WIN;
        end else if (master_program_enable) begin
            next_mpe_cnt = mpe_cnt - 3'h1;
            if (mpe_cnt == 3'h1) begin
                next_mpe = 1'b0;
            end
        end
        if (addr_wr && !program_strobe) begin
            next_addr = pwdata[ADDR_W-1:0];
        end
        if (ee_read) begin
            next_data = ee_rdata;
        end else if (data_wr) begin
            next_data = pwdata[7:0];
        end
        if (start) begin
            next_halt_cnt = EAC_HALT_PROG;
        end else if (rd_go) begin
            next_halt_cnt = EAC_HALT_READ;
        end else if (halt_cnt != 3'h0) begin
            next_halt_cnt = halt_cnt - 3'h1;
        end
        next_halt = (next_halt_cnt != 3'h0);
        next_irq  = ready_irq_enable & gie & ~program_strobe;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_irq_enable      <= 1'b0;
            master_program_enable <= 1'b0;
            mpe_cnt               <= 3'h0;
            ee_addr               <= '0;
            ee_wdata              <= 8'h00;
            ee_read               <= 1'b0;
            halt_cnt              <= 3'h0;
            cpu_halt              <= 1'b0;
            ready_irq             <= 1'b0;
            rst_q1                <= 1'b0;
            sys_run               <= 1'b0;
        end else begin
            ready_irq_enable      <= next_rie;
            master_program_enable <= next_mpe;
            mpe_cnt               <= next_mpe_cnt;
            ee_addr               <= next_addr;
            ee_wdata              <= next_data;
            ee_read               <= next_read;
            halt_cnt              <= next_halt_cnt;
            cpu_halt              <= next_halt;
            ready_irq             <= next_irq;
            rst_q1                <= 1'b1;
            sys_run               <= rst_q1;
        end
    end

    // ****************************************************************
    // programming engine: survives system reset except the idle mode field, cleared by power-on
    // ****************************************************************
    always_comb begin
        next_state   = state;
        next_pe      = program_strobe;
        next_mode    = prog_mode_field;
        next_erase   = ee_erase;
        next_write   = ee_write;
        next_tstart  = 1'b0;
        next_tcycles = tcycles;
        if (ctrl_wr && !program_strobe) begin
            next_mode = pwdata[EAC_MODE_HI:EAC_MODE_LO];
        end
        if (!sys_run && !program_strobe) begin
            next_mode = EAC_MODE_RST;
        end
        unique case (state)
            ENG_IDLE: begin
                if (start) begin
                    next_pe = 1'b1;
                    if (prog_mode_field == EAC_MODE_RSVD) begin
                        next_state = ENG_DONE;
                    end else begin
                        next_state   = ENG_PROG;
                        next_tstart  = 1'b1;
                        next_erase   = (prog_mode_field != EAC_MODE_WRIT);
                        next_write   = (prog_mode_field != EAC_MODE_ERAS);
                        next_tcycles = (prog_mode_field == EAC_MODE_ATOM)
                                     ? 16'(PROG_RC_ATOMIC) : 16'(PROG_RC_SPLIT);
                    end
                end
            end
            ENG_PROG: begin
                if (tif.done) begin
                    next_state = ENG_DONE;
                    next_erase = 1'b0;
                    next_write = 1'b0;
                end
            end
            ENG_DONE: begin
                next_pe    = 1'b0;
                next_state = ENG_IDLE;
            end
            default: begin
                next_pe    = 1'b0;
                next_erase = 1'b0;
                next_write = 1'b0;
                next_state = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            state           <= ENG_IDLE;
            program_strobe  <= 1'b0;
            prog_mode_field <= EAC_MODE_RST;
            ee_erase        <= 1'b0;
            ee_write        <= 1'b0;
            tstart          <= 1'b0;
            tcycles         <= 16'h0000;
        end else begin
            state           <= next_state;
            program_strobe  <= next_pe;
            prog_mode_field <= next_mode;
            ee_erase        <= next_erase;
            ee_write        <= next_write;
            tstart          <= next_tstart;
            tcycles         <= next_tcycles;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !por_n);

    a_resv_zero: assert property (
        setup && !pwrite && eac_hit(paddr, EAC_OFF_CTRL) |=> prdata[7:6] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_mode_frozen: assert property (
        program_strobe && ctrl_wr |=> $stable(prog_mode_field))
        else $error("mode changed while programming");
    a_mpe_timeout: assert property (
        $fell(master_program_enable) |-> $past(mpe_set, 5))
        else $error("master enable not cleared four cycles after set");
    a_strobe_gated: assert property (
        ctrl_wr && pwdata[EAC_BIT_PE] && !master_program_enable && !program_strobe
        |=> !program_strobe)
        else $error("strobe took effect without master enable");
    a_start_prog: assert property (
        start && prog_mode_field != EAC_MODE_RSVD |=> program_strobe && tstart)
        else $error("armed strobe did not start programming");
    a_flash_busy: assert property (
        self_program_enable && !program_strobe |=> !program_strobe)
        else $error("programming started during flash write");
    a_prog_halt: assert property (
        $rose(program_strobe) |-> cpu_halt [*2] ##1 !cpu_halt)
        else $error("program strobe halt not two cycles");
    a_read_halt: assert property (
        rd_go |=> ee_read ##0 cpu_halt [*4] ##1 !cpu_halt)
        else $error("read halt not four cycles");
    a_irq_level: assert property (
        ready_irq_enable && gie && !program_strobe |=> ready_irq)
        else $error("ready interrupt not requested");
    a_addr_frozen: assert property (
        program_strobe && addr_wr |=> $stable(ee_addr) && !ee_read)
        else $error("address changed during programming");
    a_resv_mode: assert property (
        start && prog_mode_field == EAC_MODE_RSVD |=> ##[1:2] !program_strobe && !ee_write)
        else $error("reserved mode not finished promptly");
    a_done_clear: assert property (
        state == ENG_PROG && tif.done |=> ##1 !program_strobe && !ee_erase)
        else $error("strobe not cleared at end of programming");

    c_write_done: cover property (state == ENG_PROG && tif.done);
    c_read: cover property (rd_go ##1 ee_read);
    c_mpe_expire: cover property ($fell(master_program_enable) && !program_strobe);
    c_refused_read: cover property (ctrl_wr && pwdata[EAC_BIT_RE] && program_strobe);
endmodule

//--- bench/eac_top_bench.sv
// testbench: self-checking bench of the nonvolatile access control block
`timescale 1ns/10ps
module eac_top_bench
    import eac_pkg::*;
();
    // ************************************************
    // stimulus, array model and design
    // ************************************************
    localparam int PRA = 12;
    localparam int PRS = 6;
    localparam int RCP = 8;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        por_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        gie     = 1'b0;
    logic        spe     = 1'b0;
    logic        rc_clk  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  ee_addr;
    logic [7:0]  ee_wdata;
    logic        ee_erase;
    logic        ee_write;
    logic        ee_read;
    logic        cpu_halt;
    logic        ready_irq;
    logic [7:0]  mem [0:511];
    int          rc_cnt  = 0;
    int          now     = 0;
    int          errors  = 0;
    int          n_checks = 0;

    always #25 pclk = ~pclk;
    // rc oscillator: one rising edge every RCP bus cycles
    always @(posedge pclk) begin
        now <= now + 1;
        rc_cnt <= (rc_cnt == RCP / 2 - 1) ? 0 : rc_cnt + 1;
        if (rc_cnt == RCP / 2 - 1) begin
            rc_clk <= ~rc_clk;
        end
    end
    // array: erase leaves ones, write stores the data byte
    always @(posedge pclk) begin
        if (ee_write) begin
            mem[ee_addr] <= ee_wdata;
        end else if (ee_erase) begin
            mem[ee_addr] <= 8'hFF;
        end
    end

    eac_top #(.PROG_RC_ATOMIC(PRA), .PROG_RC_SPLIT(PRS)) dut (
        .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gie(gie),
        .self_program_enable(spe), .rc_clk_in(rc_clk), .ee_rdata(mem[ee_addr]),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_erase(ee_erase),
        .ee_write(ee_write), .ee_read(ee_read), .cpu_halt(cpu_halt),
        .ready_irq(ready_irq));

    // ************************************************
    // tasks
    // ************************************************
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            errors++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    // counts halt, read pulse and array activity over n cycles
    task automatic watch(input int n, output int nh, output int nr, output int nw);
        nh = 0;
        nr = 0;
        nw = 0;
        repeat (n) begin
            @(posedge pclk);
            nh += int'(cpu_halt === 1'b1);
            nr += int'(ee_read === 1'b1);
            nw += int'(ee_erase === 1'b1 || ee_write === 1'b1);
        end
    endtask

    task automatic wait_idle;
        logic [31:0] q;
        int          k;
        for (k = 0; k < 200; k++) begin
            rd(EAC_OFF_CTRL, q);
            if (q[EAC_BIT_PE] === 1'b0) break;
        end
        if (k == 200) begin
            errors++;
            close_out();
        end
    endtask

    task automatic rst_pulse;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        int          nh, nr, nw, m, t0, n;
        logic [31:0] q;
        logic        e;
        logic [8:0]  a;
        logic [7:0]  d;
        void'($urandom(32'h228945A7));
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(EAC_OFF_CTRL, q);
        chk("ctrl_reset", q, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, q, e);
        chk("unmapped_err", 32'(e), 32'h1);
        chk("unmapped_data", q, 32'h0);
        wr(EAC_OFF_CTRL, 32'hFFFFFFF8);
        rd(EAC_OFF_CTRL, q);
        chk("ctrl_reserved", q, 32'h38);
        wr(EAC_OFF_CTRL, 32'h0);
        wr(EAC_OFF_CTRL, 32'h2);
        watch(6, nh, nr, nw);
        rd(EAC_OFF_CTRL, q);
        chk("strobe_no_mpe", q + 32'(nh + nw), 32'h0);
        spe <= 1'b1;
        wr(EAC_OFF_CTRL, 32'h4);
        wr(EAC_OFF_CTRL, 32'h2);
        rd(EAC_OFF_CTRL, q);
        chk("strobe_flash_busy", q, 32'h0);
        spe <= 1'b0;
        wr(EAC_OFF_CTRL, 32'h4);
        rd(EAC_OFF_CTRL, q);
        chk("mpe_set", q, 32'h4);
        rd(EAC_OFF_CTRL, q);
        chk("mpe_cleared", q, 32'h0);
        wr(EAC_OFF_CTRL, 32'h2);
        rd(EAC_OFF_CTRL, q);
        chk("strobe_late", q, 32'h0);
        gie <= 1'b1;
        for (m = 0; m < 3; m++) begin
            a = 9'($urandom);
            d = 8'($urandom);
            n = (m == 0) ? PRA : PRS;
            gie <= 1'b0;
            wr(EAC_OFF_ADDR, 32'(a));
            wr(EAC_OFF_DATA, 32'(d));
            wr(EAC_OFF_CTRL, 32'(m * 16) | 32'h0C);
            wr(EAC_OFF_CTRL, 32'(m * 16) | 32'h0A);
            gie <= 1'b1;
            t0 = now;
            watch(6, nh, nr, nw);
            chk("prog_halt", 32'(nh), 32'(EAC_HALT_PROG));
            chk("erase", 32'(ee_erase), 32'(m != 2));
            chk("write", 32'(ee_write), 32'(m != 1));
            chk("wdata", 32'(ee_wdata), 32'(d));
            chk("irq_busy", 32'(ready_irq), 32'h0);
            wr(EAC_OFF_CTRL, 32'h3A);
            wr(EAC_OFF_ADDR, 32'(~a));
            wr(EAC_OFF_CTRL, 32'(m * 16) | 32'h09);
            watch(4, nh, nr, nw);
            chk("read_refused", 32'(nr), 32'h0);
            chk("addr_frozen", 32'(ee_addr), 32'(a));
            wait_idle();
            t0 = now - t0;
            chk("prog_time", 32'(t0 >= (n - 1) * RCP && t0 <= (n + 1) * RCP + 12), 32'h1);
            chk("irq_ready", 32'(ready_irq), 32'h1);
            rd(EAC_OFF_CTRL, q);
            chk("mode_kept", q, 32'(m * 16) | 32'h08);
            wr(EAC_OFF_CTRL, 32'(m * 16) | 32'h09);
            watch(8, nh, nr, nw);
            chk("read_halt", 32'(nh), 32'(EAC_HALT_READ));
            chk("read_pulse", 32'(nr), 32'h1);
            rd(EAC_OFF_DATA, q);
            chk("read_data", q, (m == 1) ? 32'hFF : 32'(d));
        end
        gie <= 1'b0;
        watch(3, nh, nr, nw);
        chk("irq_gie_off", 32'(ready_irq), 32'h0);
        wr(EAC_OFF_CTRL, 32'h34);
        wr(EAC_OFF_CTRL, 32'h32);
        watch(6, nh, nr, nw);
        rd(EAC_OFF_CTRL, q);
        chk("rsvd_mode_ctrl", q, 32'h30);
        chk("rsvd_mode_idle", 32'(nw), 32'h0);
        wr(EAC_OFF_CTRL, 32'h14);
        wr(EAC_OFF_CTRL, 32'h12);
        rst_pulse();
        rd(EAC_OFF_CTRL, q);
        chk("reset_busy", q, 32'h12);
        wait_idle();
        rst_pulse();
        rd(EAC_OFF_CTRL, q);
        chk("reset_idle", q, 32'h0);
        close_out();
    end
endmodule
